// ==== flag_update_pkg.sv ====
// package: descriptor field layout, modes and carrier types for the flag updater
package flag_update_pkg;

   // descriptor field positions
   localparam int unsigned DESC_W = 64;
   localparam int unsigned DBM_BIT = 51;
   localparam int unsigned AF_BIT = 10;
   localparam int unsigned S1AP2_BIT = 7;
   localparam int unsigned S2AP1_BIT = 7;
   localparam int unsigned S2AP0_BIT = 6;
   localparam logic [1:0] SPLIT_STAGE_MODE = 2'h2;

   // register offsets, byte addresses on the APB
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_COUNT = 12'h008;
   localparam logic [11:0] OFS_SYNC = 12'h00C;

   // control register field positions and reset value
   localparam int unsigned CTRL_AF_EN = 0;
   localparam int unsigned CTRL_DIRTY_EN = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_EVAL = 3'b010,
      ST_SWAP = 3'b011,
      ST_DONE = 3'b100
   } walk_state_e;

   // request from the walker for one descriptor
   typedef struct packed {
      logic [DESC_W-1:0] addr;
      logic stage2;
      logic is_write;
      logic is_ats;
      logic nested;
      logic s1_readonly;
      logic table_limit;
      logic ctx_fetch;
      logic final_s2;
      logic s2_out_writable;
      logic [1:0] ts_mode;
   } walk_req_s;

   // answer back to the walker
   typedef struct packed {
      logic perm_fault;
      logic access_fault;
      logic write_grant;
      logic updated;
   } walk_rsp_s;

   // atomic compare-and-swap request to coherent memory
   typedef struct packed {
      logic [DESC_W-1:0] addr;
      logic [DESC_W-1:0] compare;
      logic [DESC_W-1:0] swap;
   } mem_cas_s;

endpackage : flag_update_pkg

// ==== dirty_flag_hw_update.sv ====
// dirty and access flag hardware update for one translation table walker
`timescale 1ns/1ps

module dirty_flag_hw_update (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // walker request and answer
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire flag_update_pkg::walk_req_s req_i,
   input wire logic final_s2_done_i,
   output logic rsp_valid_o,
   output flag_update_pkg::walk_rsp_s rsp_o,
   // completion and invalidation events
   input wire logic op_complete_i,
   input wire logic tlbi_complete_i,
   // memory port: read then compare-and-swap
   output logic mem_rd_valid_o,
   output logic [flag_update_pkg::DESC_W-1:0] mem_rd_addr_o,
   input wire logic mem_rd_done_i,
   input wire logic [flag_update_pkg::DESC_W-1:0] mem_rd_data_i,
   output logic mem_cas_valid_o,
   output flag_update_pkg::mem_cas_s mem_cas_o,
   input wire logic mem_cas_done_i,
   input wire logic mem_cas_ok_i,
   // visibility barrier to the interconnect
   output logic barrier_o,
   input wire logic barrier_done_i
);
   import flag_update_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // state

   typedef struct packed {
      walk_state_e st;
      walk_req_s req;
      logic [DESC_W-1:0] desc;
      logic [DESC_W-1:0] new_desc;
      walk_rsp_s rsp;
      logic rsp_valid;
      logic [31:0] ctrl;
      logic [15:0] upd_count;
      logic [15:0] retry_count;
      logic pending;
      logic barrier;
      logic sync_done;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } state_s;

   state_s q, d;

   ////////////////////////////////////////////////////////////////////////
   // descriptor decode helpers

   // writable in its current permission state, ignoring the modifier
   function automatic logic is_dirty(input logic [DESC_W-1:0] ds, input logic s2);
      is_dirty = s2 ? ds[S2AP1_BIT] : !ds[S1AP2_BIT];
   endfunction : is_dirty

   // descriptor intended as writable but not yet marked
   function automatic logic is_clean(input logic [DESC_W-1:0] ds, input logic s2);
      is_clean = !is_dirty(ds, s2) && ds[DBM_BIT];
   endfunction : is_clean

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic af_en;
      logic dirty_en;
      logic may_dirty;
      logic want_dirty;
      logic need_af;
      logic split;
      logic skip_final;
      logic grant;
      logic hit;
      af_en = q.ctrl[CTRL_AF_EN];
      dirty_en = q.ctrl[CTRL_DIRTY_EN] && af_en;
      may_dirty = 1'b0;
      want_dirty = 1'b0;
      need_af = 1'b0;
      split = 1'b0;
      skip_final = 1'b0;
      grant = 1'b0;
      hit = 1'b0;
      d = q;
      d.rsp_valid = 1'b0;
      d.pready = 1'b0;
      d.pslverr = 1'b0;
      d.barrier = q.barrier;

      // apb access phase: one wait cycle then pready
      if (psel_i && penable_i && !q.pready) begin
         d.pready = 1'b1;
         d.prdata = 32'h0000_0000;
         hit = 1'b1;
         case (paddr_i)
            OFS_CTRL: begin
               if (pwrite_i) begin
                  d.ctrl = {30'h0, pwdata_i[1:0]};
               end
               d.prdata = q.ctrl;
            end
            OFS_STATUS: d.prdata = {28'h000_0000, q.sync_done, q.barrier, q.pending,
                                    q.st != ST_IDLE};
            OFS_COUNT: d.prdata = {q.retry_count, q.upd_count};
            OFS_SYNC: begin
               // a sync request publishes all updates of completed work
               if (pwrite_i && pwdata_i[0]) begin
                  d.barrier = q.pending || q.barrier;
                  d.sync_done = !(q.pending || q.barrier);
               end
               d.prdata = {31'h0, q.sync_done};
            end
            default: hit = 1'b0;
         endcase
         d.pslverr = !hit;
      end

      // an invalidation completion flushes updates too
      if (tlbi_complete_i && q.pending) begin
         d.barrier = 1'b1;
      end
      if (q.barrier && barrier_done_i) begin
         d.barrier = 1'b0;
         d.pending = 1'b0;
         d.sync_done = 1'b1;
      end
      // a completion in the cycle the barrier finishes stays pending for next sync
      if (op_complete_i && q.upd_count != 16'h0000) begin
         d.pending = 1'b1;
      end

      case (q.st)
         ST_IDLE: begin
            if (req_valid_i) begin
               d.req = req_i;
               d.st = ST_READ;
            end
         end
         ST_READ: begin
            if (mem_rd_done_i) begin
               d.desc = mem_rd_data_i;
               d.st = ST_EVAL;
            end
         end
         ST_EVAL: begin
            split = q.req.is_ats && q.req.ts_mode == SPLIT_STAGE_MODE;
            // final s2 already done (final_s2_done_i) is left alone by a later non-service access
            skip_final = q.req.final_s2 && !q.req.is_ats && final_s2_done_i;
            need_af = af_en && !q.desc[AF_BIT] && !skip_final;
            may_dirty = dirty_en && q.req.is_write && is_clean(q.desc, q.req.stage2)
                        && !q.req.table_limit
                        && !(q.req.stage2 && q.req.ctx_fetch)
                        && !(q.req.nested && q.req.s1_readonly && q.req.is_ats)
                        && !(!q.req.stage2 && q.req.nested && !q.req.s2_out_writable)
                        && !skip_final;
            want_dirty = may_dirty;
            grant = is_dirty(q.desc, q.req.stage2) || may_dirty;
            // split-stage completion counts a clean final s2 as writable unless s1_readonly
            if (split && q.req.stage2 && q.req.final_s2 && is_clean(q.desc, 1'b1)) begin
               grant = !q.req.s1_readonly;
            end
            d.rsp.access_fault = !q.desc[AF_BIT] && !af_en;
            // access-flag-only or no modifier: write is refused
            d.rsp.perm_fault = q.req.is_write && !grant && !q.req.is_ats;
            d.rsp.write_grant = q.req.is_write && grant;
            d.rsp.updated = 1'b0;
            d.new_desc = q.desc;
            if (need_af) begin
               d.new_desc[AF_BIT] = 1'b1;
            end
            if (want_dirty) begin
               if (q.req.stage2) begin
                  d.new_desc[S2AP1_BIT] = 1'b1;
               end else begin
                  d.new_desc[S1AP2_BIT] = 1'b0;
               end
               d.new_desc[AF_BIT] = 1'b1;
            end
            d.new_desc[DBM_BIT] = q.desc[DBM_BIT];
            d.st = (need_af || want_dirty) ? ST_SWAP : ST_DONE;
         end
         ST_SWAP: begin
            if (mem_cas_done_i) begin
               if (mem_cas_ok_i) begin
                  d.rsp.updated = 1'b1;
                  d.upd_count = q.upd_count + 16'h0001;
                  d.st = ST_DONE;
               end else begin
                  // memory changed under us: fetch and decide again
                  d.retry_count = q.retry_count + 16'h0001;
                  d.st = ST_READ;
               end
            end
         end
         ST_DONE: begin
            d.rsp_valid = 1'b1;
            d.st = ST_IDLE;
         end
         default: d.st = ST_IDLE;
      endcase

      if (srst_i) begin
         d = '0;
         d.st = ST_IDLE;
         d.ctrl = CTRL_RESET;
      end
   end

   // single register bank
   always_ff @(posedge ref_clk_i) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign req_ready_o = q.st == ST_IDLE;
   assign rsp_valid_o = q.rsp_valid;
   assign rsp_o = q.rsp;
   assign mem_rd_valid_o = q.st == ST_READ;
   assign mem_rd_addr_o = q.req.addr;
   // swap only succeeds if memory still holds what was evaluated
   assign mem_cas_valid_o = q.st == ST_SWAP;
   assign mem_cas_o = '{addr: q.req.addr, compare: q.desc, swap: q.new_desc};
   assign barrier_o = q.barrier;
   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;

   ////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_swap_issue;
      q.st == ST_SWAP && mem_cas_valid_o;
   endsequence

   a_dbm_kept: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue |-> mem_cas_o.swap[DBM_BIT] == mem_cas_o.compare[DBM_BIT])
      else $error("modifier bit changed by swap");

   a_af_never_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue |-> !(mem_cas_o.compare[AF_BIT] && !mem_cas_o.swap[AF_BIT]))
      else $error("access flag cleared");

   a_s2_never_clear: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue and q.req.stage2 |->
         !(mem_cas_o.compare[S2AP1_BIT] && !mem_cas_o.swap[S2AP1_BIT]))
      else $error("stage 2 write bit cleared");

   a_s1_never_set: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue and !q.req.stage2 |->
         !(!mem_cas_o.compare[S1AP2_BIT] && mem_cas_o.swap[S1AP2_BIT]))
      else $error("stage 1 read-only bit set");

   a_no_dbm_no_write: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue and !mem_cas_o.compare[DBM_BIT] |->
         mem_cas_o.swap[S1AP2_BIT] == mem_cas_o.compare[S1AP2_BIT])
      else $error("made writable without modifier");

   a_ctx_fetch: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue and (q.req.stage2 && q.req.ctx_fetch) |->
         mem_cas_o.swap[S2AP1_BIT] == mem_cas_o.compare[S2AP1_BIT])
      else $error("context fetch descriptor made dirty");

   a_retry_reads: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      q.st == ST_SWAP && mem_cas_done_i && !mem_cas_ok_i |=> mem_rd_valid_o)
      else $error("failed swap not re-read");

   a_rsp_after_swap: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      q.st == ST_SWAP && mem_cas_done_i && mem_cas_ok_i |=> ##1 rsp_valid_o && rsp_o.updated)
      else $error("response not after update");

   a_tlbi_flush: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      tlbi_complete_i && q.pending && !barrier_done_i |=> barrier_o)
      else $error("invalidation did not publish updates");

   a_apb_ready: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      psel_i && penable_i && !pready_o |=> pready_o)
      else $error("apb answer late");

   // a completed read feeds the compare word of the swap two cycles later
   sequence s_read_done;
      mem_rd_valid_o && mem_rd_done_i;
   endsequence

   // evaluation of a write; its verdict stands on rsp_o from the next edge
   sequence s_eval_write;
      q.st == ST_EVAL && q.req.is_write;
   endsequence

   a_swap_of_read: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_read_done ##1 q.st == ST_EVAL ##1 s_swap_issue |->
         mem_cas_o.compare == $past(mem_rd_data_i, 2))
      else $error("swap compare word is not the fetched descriptor");

   a_no_dbm_fault: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_eval_write and (!q.req.is_ats && !q.desc[DBM_BIT]
         && !is_dirty(q.desc, q.req.stage2)) |=> rsp_o.perm_fault)
      else $error("write without modifier did not fault");

   a_dirty_no_fault: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_eval_write and is_dirty(q.desc, q.req.stage2) |=> !rsp_o.perm_fault)
      else $error("write to dirty page faulted");

   a_af_only_deny: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_eval_write and (q.req.is_ats && !q.ctrl[CTRL_DIRTY_EN]
         && q.req.ts_mode != SPLIT_STAGE_MODE
         && !is_dirty(q.desc, q.req.stage2)) |=> !rsp_o.write_grant)
      else $error("service write granted without dirty update");

   a_table_limit: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue and q.req.table_limit |->
         mem_cas_o.swap[S1AP2_BIT] == mem_cas_o.compare[S1AP2_BIT])
      else $error("table-limited descriptor made dirty");

   a_nested_ro_ats: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_swap_issue and (q.req.is_ats && q.req.nested && q.req.s1_readonly) |->
         mem_cas_o.swap[S1AP2_BIT] == mem_cas_o.compare[S1AP2_BIT])
      else $error("read-only nested service request made dirty");

   a_ats_sets_af: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      q.st == ST_EVAL && q.req.is_ats && q.ctrl[CTRL_AF_EN] && !q.desc[AF_BIT] |=>
         mem_cas_valid_o && mem_cas_o.swap[AF_BIT])
      else $error("service request did not set access flag");

   a_s2_marks_dirty: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_eval_write and (q.req.stage2 && !q.req.is_ats && q.ctrl[CTRL_AF_EN]
         && q.ctrl[CTRL_DIRTY_EN] && is_clean(q.desc, 1'b1) && !q.req.table_limit
         && !q.req.ctx_fetch && !q.req.final_s2) |=>
         mem_cas_valid_o && mem_cas_o.swap[S2AP1_BIT])
      else $error("clean stage 2 write not marked dirty");

   a_sync_publish: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      barrier_o && barrier_done_i |=> !barrier_o)
      else $error("barrier held after completion");

endmodule : dirty_flag_hw_update

// ==== desc_mem_model.sv ====
// coherent memory model holding descriptors, answering reads, swaps and barriers
`timescale 1ns/1ps
module desc_mem_model (
   input wire logic ref_clk_i,
   input wire logic [3:0] dly_i,
   input wire logic rd_valid_i,
   input wire logic [63:0] rd_addr_i,
   output logic rd_done_o,
   output logic [63:0] rd_data_o,
   input wire logic cas_valid_i,
   input wire flag_update_pkg::mem_cas_s cas_i,
   output logic cas_done_o,
   output logic cas_ok_o,
   input wire logic barrier_i,
   output logic barrier_done_o
);
   import flag_update_pkg::*;
   // dirty bit modifier at bit 51 is only data here
   logic [63:0] mem [8];
   logic [3:0] cnt;
   logic busy;
   initial begin
      {rd_done_o, cas_done_o, cas_ok_o, barrier_done_o, cnt, rd_data_o} = '0;
   end
   assign busy = (rd_valid_i && !rd_done_o) || (cas_valid_i && !cas_done_o)
      || (barrier_i && !barrier_done_o);
   ////////////////////////////////////////////////////////////////////////////////
   // one request at a time, answered after dly_i waiting cycles
   always @(posedge ref_clk_i) begin
      rd_done_o <= 1'b0;
      cas_done_o <= 1'b0;
      barrier_done_o <= 1'b0;
      rd_data_o <= ~rd_data_o; // idle data bus never keeps the old word
      cnt <= busy ? cnt + 4'h1 : 4'h0;
      if (busy && cnt >= dly_i) begin
         cnt <= 4'h0;
         if (rd_valid_i) begin
            rd_done_o <= 1'b1;
            rd_data_o <= mem[rd_addr_i[5:3]];
         end else if (cas_valid_i) begin
            // swap lands only if nobody changed the word meanwhile
            cas_done_o <= 1'b1;
            cas_ok_o <= mem[cas_i.addr[5:3]] === cas_i.compare;
            if (mem[cas_i.addr[5:3]] === cas_i.compare) begin
               mem[cas_i.addr[5:3]] <= cas_i.swap;
            end
         end else begin
            barrier_done_o <= 1'b1;
         end
      end
   end
endmodule : desc_mem_model

// ==== tb_dirty_flag_hw_update.sv ====
// self-checking bench for the descriptor flag updater
`timescale 1ns/1ps
module tb_dirty_flag_hw_update;
   import flag_update_pkg::*;
   localparam logic [63:0] A = 64'h1 << AF_BIT;
   localparam logic [63:0] D = 64'h1 << DBM_BIT;
   localparam logic [63:0] P = 64'h1 << S1AP2_BIT;
   localparam logic [63:0] X = 64'h1 << 55;
   localparam logic [10:0] S2 = 11'h400, WR = 11'h200, ATS = 11'h100, NST = 11'h080;
   localparam logic [10:0] S1RO = 11'h040, TL = 11'h020, CTX = 11'h010, FS2 = 11'h008;
   localparam logic [10:0] OW = 11'h004, SPL = 11'h002;
   logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, req_valid = 0, fs2_done = 0;
   logic op_c = 0, tlbi_c = 0, pready, pslverr, req_ready, rsp_valid, er;
   logic rd_v, rd_d, cas_v, cas_d, cas_ok, bar, bar_d;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [63:0] rd_a, rd_dat;
   logic [3:0] dly = '0;
   walk_req_s req = '0;
   walk_rsp_s rsp;
   mem_cas_s cas;
   int fails = 0, samples_checked = 0;
   always #10 clk = ~clk;
   dirty_flag_hw_update dirty_flag_hw_update_inst (.ref_clk_i(clk), .srst_i(srst),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .req_valid_i(req_valid),
      .req_ready_o(req_ready), .req_i(req), .final_s2_done_i(fs2_done),
      .rsp_valid_o(rsp_valid), .rsp_o(rsp), .op_complete_i(op_c), .tlbi_complete_i(tlbi_c),
      .mem_rd_valid_o(rd_v), .mem_rd_addr_o(rd_a), .mem_rd_done_i(rd_d),
      .mem_rd_data_i(rd_dat), .mem_cas_valid_o(cas_v), .mem_cas_o(cas),
      .mem_cas_done_i(cas_d), .mem_cas_ok_i(cas_ok), .barrier_o(bar),
      .barrier_done_i(bar_d));
   desc_mem_model desc_mem_model_inst (.ref_clk_i(clk), .dly_i(dly), .rd_valid_i(rd_v),
      .rd_addr_i(rd_a), .rd_done_o(rd_d), .rd_data_o(rd_dat), .cas_valid_i(cas_v),
      .cas_i(cas), .cas_done_o(cas_d), .cas_ok_o(cas_ok), .barrier_i(bar),
      .barrier_done_o(bar_d));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // bounded wait, sampled mid-cycle so edge updates have landed
   task automatic wait_for(input int sel);
      for (int i = 0; i < 300; i++) begin
         @(negedge clk);
         if ((sel == 0 && req_ready === 1'b1) || (sel == 1 && rsp_valid === 1'b1) ||
            (sel == 2 && cas_v === 1'b1) || (sel == 3 && bar === 1'b1) ||
            (sel == 4 && pready === 1'b1)) return;
      end
      $display("MISMATCH t=%0t wait %0d timed out", $time, sel);
      fails++;
      print_verdict();
   endtask : wait_for
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      bit got = 1'b0;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      // request stands until pready is seen high at a rising edge
      for (int i = 0; i < 300 && !got; i++) begin
         @(posedge clk);
         if (pready === 1'b1) begin
            rd = prdata;
            er = pslverr;
            got = 1'b1;
         end
      end
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
      if (!got) begin
         $display("MISMATCH t=%0t apb answer timed out", $time);
         fails++;
         print_verdict();
      end
   endtask : apb
   // one walker request on descriptor slot 3, then response and memory checks
   task automatic run(input logic [63:0] d, input logic [10:0] f, input logic [63:0] e,
      input logic [3:0] m, input logic [3:0] v);
      desc_mem_model_inst.mem[3] = d;
      req <= walk_req_s'({64'h18, f});
      req_valid <= 1'b1;
      wait_for(0);
      @(posedge clk);
      req_valid <= 1'b0;
      wait_for(1);
      chk({60'h0, rsp & m}, {60'h0, v});
      chk(desc_mem_model_inst.mem[3], e);
      @(posedge clk);
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence; rsp bits are {perm_fault, access_fault, write_grant, updated}
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, CTRL_RESET);
      apb(1'b0, 12'h010, 32'h0);
      chk({er, rd}, 33'h1_0000_0000);
      apb(1'b1, OFS_CTRL, 32'h3);
      run(A | D | P, WR | OW, A | D, 4'h8, 4'h0);
      run(A | P, WR | OW, A | P, 4'h8, 4'h8);
      run(A | D | P, WR | OW | TL, A | D | P, 4'h8, 4'h8);
      run(A | D, S2 | WR | OW, A | D | P, 4'h8, 4'h0);
      run(A, S2 | WR | OW, A, 4'h8, 4'h8);
      dly <= 4'h3;
      run(A, WR | OW, A, 4'h8, 4'h0);
      run(A | D, S2 | WR | CTX | OW, A | D, 4'h8, 4'h8);
      run(A | D | P, WR | NST, A | D | P, 4'h8, 4'h8);
      run(P, 11'h0, P | A, 4'h4, 4'h0);
      run(P, ATS, P | A, 4'h5, 4'h1);
      run(A | D | P, ATS | WR | OW, A | D, 4'h2, 4'h2);
      run(A | D | P, ATS | WR | NST | S1RO | OW, A | D | P, 4'h2, 4'h0);
      run(A | D, S2 | ATS | WR | FS2 | OW | SPL, A | D | P, 4'h2, 4'h2);
      // final stage 2 already handled by the service request: left alone
      fs2_done <= 1'b1;
      run(D, S2 | WR | FS2 | OW, D, 4'h1, 4'h0);
      fs2_done <= 1'b0;
      fork
         run(A | D | P, WR | OW, A | D | X, 4'h8, 4'h0);
         begin
            wait_for(2);
            desc_mem_model_inst.mem[3] = A | D | P | X;
         end
      join
      apb(1'b1, OFS_CTRL, 32'h1);
      run(A | D | P, ATS | WR | OW, A | D | P, 4'h2, 4'h0);
      apb(1'b1, OFS_CTRL, 32'h3);
      // completed transaction, then a sync must publish it
      run(A | D | P, WR | OW, A | D, 4'h8, 4'h0);
      op_c <= 1'b1;
      @(posedge clk);
      op_c <= 1'b0;
      apb(1'b1, OFS_SYNC, 32'h1);
      wait_for(3);
      rd = '0;
      for (int k = 0; k < 20 && rd[0] !== 1'b1; k++) apb(1'b0, OFS_SYNC, 32'h0);
      chk(rd[0], 1'b1);
      run(A | D, S2 | WR | OW, A | D | P, 4'h8, 4'h0);
      // the completion must be pending before the invalidation finishes
      op_c <= 1'b1;
      @(posedge clk);
      op_c <= 1'b0;
      tlbi_c <= 1'b1;
      @(posedge clk);
      tlbi_c <= 1'b0;
      wait_for(3);
      chk(bar, 1'b1);
      repeat (10) @(posedge clk);
      print_verdict();
   end
endmodule : tb_dirty_flag_hw_update
